/* common/gprf_pkg.sv */
// constants and types shared by the general purpose register file
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package gprf_pkg;

  // ------------------------------------------------------------
  // widths and counts
  // ------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned BE_W = DATA_W / BYTE_W;
  localparam int unsigned NUM_GPR = 8;
  localparam int unsigned NUM_BYTE_GPR = 4;
  localparam int unsigned NUM_SEG = 6;
  localparam int unsigned POS_W = 5;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned REGION_LSB = IDX_LSB + IDX_W;
  localparam int unsigned REGION_W = ADDR_W - REGION_LSB;
  localparam int unsigned STAT_W = 4;
  localparam int unsigned CPL_W = 2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] GPR_RST = 32'h0000_0000;
  localparam logic [HALF_W-1:0] SEL_RST = 16'h0000;
  localparam logic [CPL_W-1:0] CPL_RST = 2'h0;
  localparam logic [CPL_W-1:0] CPL_KERNEL = 2'h0;

  // ------------------------------------------------------------
  // address map: 32-byte regions, word index inside
  // ------------------------------------------------------------
  localparam logic [REGION_W-1:0] RGN_FULL = 5'h00;
  localparam logic [REGION_W-1:0] RGN_HALF = 5'h01;
  localparam logic [REGION_W-1:0] RGN_BYTE = 5'h02;
  localparam logic [REGION_W-1:0] RGN_CTRL = 5'h03;
  localparam logic [REGION_W-1:0] RGN_SYS = 5'h04;
  localparam logic [REGION_W-1:0] RGN_DBG = 5'h05;
  localparam logic [REGION_W-1:0] RGN_FPU = 5'h06;
  localparam logic [REGION_W-1:0] RGN_STAGE = 5'h08;
  localparam logic [REGION_W-1:0] RGN_STAGE_SEL = 5'h09;
  localparam logic [REGION_W-1:0] RGN_SEL = 5'h0a;

  localparam logic [IDX_W-1:0] CTL_OPSEL = 3'h0;
  localparam logic [IDX_W-1:0] CTL_OPERAND = 3'h1;
  localparam logic [IDX_W-1:0] CTL_ADDROP = 3'h2;
  localparam logic [IDX_W-1:0] CTL_STATUS = 3'h3;
  localparam logic [IDX_W-1:0] CTL_CPL = 3'h4;
  localparam logic [IDX_W-1:0] CTL_FIELD_WR = 3'h5;
  localparam logic [IDX_W-1:0] CTL_TSW = 3'h6;

  // status bits, sticky, write one to clear
  localparam int unsigned STAT_PRIV = 0;
  localparam int unsigned STAT_ADDR = 1;
  localparam int unsigned STAT_MODE = 2;
  localparam int unsigned STAT_TSW = 3;

  // ------------------------------------------------------------
  // operand selection
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_BIT = 3'b000,
    MODE_BYTE0 = 3'b001,
    MODE_BYTE1 = 3'b010,
    MODE_HALF = 3'b011,
    MODE_WORD = 3'b100,
    MODE_FIELD = 3'b101
  } gprf_mode_type;

  typedef struct packed {
    logic [14:0] rsvd;
    logic addr16;
    logic [POS_W-1:0] len_m1;
    logic [POS_W-1:0] pos;
    logic [IDX_W-1:0] src;
    gprf_mode_type mode;
  } gprf_opsel_type;

  localparam gprf_opsel_type OPSEL_RST = '0;

endpackage

/* dv/gprf_monitor.sv */
// bus port checker for the general purpose register file
`timescale 1ns/1ps
module gprf_monitor
  import gprf_pkg::*;
(
  input wire logic CLK_I, // core clock
  input wire logic SYS_RST_I, // sync reset
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I, // byte address
  input wire logic AVS_READ_I, // read request
  input wire logic AVS_WRITE_I, // write request
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I, // write data
  input wire logic [BE_W-1:0] AVS_BYTEENABLE_I, // byte lanes
  input wire logic [DATA_W-1:0] AVS_READDATA_O, // read data
  input wire logic AVS_WAITREQUEST_O // stall
);
  // ------
  // shadow of what the bus has written
  // ------
  wire rd_done = AVS_READ_I && !AVS_WAITREQUEST_O;
  wire wr_done = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  wire [REGION_W-1:0] rgn = AVS_ADDRESS_I[ADDR_W-1:REGION_LSB];
  wire [IDX_W-1:0] idx = AVS_ADDRESS_I[REGION_LSB-1:IDX_LSB];
  wire ctl = rgn == RGN_CTRL;
  wire [IDX_W-1:0] bsel = {1'b0, idx[1:0]};
  logic [DATA_W-1:0] shadow_reg [NUM_GPR];
  logic [NUM_GPR-1:0] known_reg;
  logic [CPL_W-1:0] cpl_reg;
  logic [2:0] mode_reg;
  logic a16_reg;
  logic [IDX_W-1:0] src_reg;
  logic [POS_W-1:0] pos_reg;
  wire [DATA_W-1:0] src_v = shadow_reg[src_reg];

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      for (int r = 0; r < NUM_GPR; r++) shadow_reg[r] <= GPR_RST;
      known_reg <= '1;
      cpl_reg <= CPL_RST;
      {a16_reg, pos_reg, src_reg, mode_reg} <= '0;
    end else if (wr_done) begin
      for (int b = 0; b < BE_W; b++) begin
        if (rgn == RGN_FULL && AVS_BYTEENABLE_I[b])
          shadow_reg[idx][b*8 +: 8] <= AVS_WRITEDATA_I[b*8 +: 8];
      end
      if (rgn == RGN_HALF) shadow_reg[idx][15:0] <= AVS_WRITEDATA_I[15:0];
      if (rgn == RGN_BYTE)
        shadow_reg[bsel][{idx[2], 3'h0} +: 8] <= AVS_WRITEDATA_I[7:0];
      // field insert and task switch leave the shadow behind
      if (ctl && (idx == CTL_FIELD_WR || idx == CTL_TSW)) known_reg <= '0;
      if (ctl && idx == CTL_CPL) cpl_reg <= AVS_WRITEDATA_I[1:0];
      if (ctl && idx == CTL_OPSEL)
        {a16_reg, pos_reg, src_reg, mode_reg} <=
          {AVS_WRITEDATA_I[16], AVS_WRITEDATA_I[10:0]};
    end
  end

  // ------
  // properties
  // ------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_wait_answer: assert property ((AVS_READ_I || AVS_WRITE_I) &&
    AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("no answer");
  a_wait_pulse: assert property ($fell(AVS_WAITREQUEST_O) |=>
    AVS_WAITREQUEST_O) else $error("waitrequest low too long");
  a_wait_rest: assert property (!AVS_READ_I && !AVS_WRITE_I |=>
    AVS_WAITREQUEST_O) else $error("waitrequest low at rest");
  a_full_value: assert property (
    rd_done && rgn == RGN_FULL && known_reg[idx] |->
    AVS_READDATA_O == shadow_reg[idx]) else $error("full word wrong");
  a_half_view: assert property (
    rd_done && rgn == RGN_HALF && known_reg[idx] |->
    AVS_READDATA_O == {16'h0000, shadow_reg[idx][15:0]})
    else $error("half view wrong");
  a_byte_view: assert property (
    rd_done && rgn == RGN_BYTE && known_reg[bsel] |->
    AVS_READDATA_O == {24'h0, shadow_reg[bsel][{idx[2], 3'h0} +: 8]})
    else $error("byte view wrong");
  a_priv_zero: assert property (
    rd_done && (rgn == RGN_SYS || rgn == RGN_DBG) && cpl_reg != CPL_KERNEL
    |-> AVS_READDATA_O == 32'h0) else $error("privileged read leaked");
  a_addr_byte: assert property (
    rd_done && ctl && idx == CTL_ADDROP &&
    (mode_reg == MODE_BYTE0 || mode_reg == MODE_BYTE1) |->
    AVS_READDATA_O == 32'h0) else $error("byte used as address");
  a_addr_word: assert property (
    rd_done && ctl && idx == CTL_ADDROP && mode_reg == MODE_WORD &&
    known_reg[src_reg] |-> AVS_READDATA_O ==
    {a16_reg ? 16'h0000 : src_v[31:16], src_v[15:0]})
    else $error("address operand wrong");
  a_oper_bit: assert property (
    rd_done && ctl && idx == CTL_OPERAND && mode_reg == MODE_BIT &&
    known_reg[src_reg] |-> AVS_READDATA_O == {31'h0, src_v[pos_reg]})
    else $error("bit operand wrong");

  c_tsw: cover property (wr_done && ctl && idx == CTL_TSW);
  c_priv: cover property (rd_done && rgn == RGN_SYS && cpl_reg != 2'h0);
  c_byte: cover property (rd_done && rgn == RGN_BYTE);
endmodule

bind gprf_top gprf_monitor i_gprf_monitor (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O)
);

/* dv/tb_top.sv */
// directed bench for the register file over its avalon-mm port
`timescale 1ns/1ps
module tb_top
  import gprf_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] adr = '0;
  logic req_rd = 1'b0;
  logic req_wr = 1'b0;
  logic [DATA_W-1:0] wdat = '0;
  logic [BE_W-1:0] lanes = '1;
  logic [DATA_W-1:0] rdat;
  logic waitr;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] m [NUM_GPR];
  logic [DATA_W-1:0] mk [6] = '{32'h1, 32'hff, 32'hff, 32'hffff,
                                32'hffff_ffff, 32'h7f};
  int sh [6] = '{9, 0, 8, 0, 0, 9};
  int bad_count = 0;
  int tests_run = 0;
  localparam logic [ADDR_W-1:0] ad_opsel = {RGN_CTRL, CTL_OPSEL, 2'b00};
  localparam logic [ADDR_W-1:0] ad_oper = {RGN_CTRL, CTL_OPERAND, 2'b00};
  localparam logic [ADDR_W-1:0] ad_addr = {RGN_CTRL, CTL_ADDROP, 2'b00};
  localparam logic [ADDR_W-1:0] ad_stat = {RGN_CTRL, CTL_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ad_cpl = {RGN_CTRL, CTL_CPL, 2'b00};
  localparam logic [ADDR_W-1:0] ad_fwr = {RGN_CTRL, CTL_FIELD_WR, 2'b00};
  localparam logic [ADDR_W-1:0] ad_tsw = {RGN_CTRL, CTL_TSW, 2'b00};

  gprf_top i_gprf_top (
    .CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(req_rd),
    .AVS_WRITE_I(req_wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(lanes),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(waitr)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  // ------
  // helpers and bus tasks
  // ------
  function automatic logic [ADDR_W-1:0] ad(input logic [REGION_W-1:0] r,
                                           input int k);
    return {r, k[IDX_W-1:0], 2'b00};
  endfunction
  function automatic logic [DATA_W-1:0] pv(input int i);
    return 32'h1357_9bdf ^ (32'h0101_0101 * i);
  endfunction
  // field length fixed at seven bits
  function automatic logic [DATA_W-1:0] os(input int md, input int src,
                                           input int pos, input logic a16);
    return {15'h0, a16, 5'h06, pos[4:0], src[2:0], md[2:0]};
  endfunction
  task automatic check(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [BE_W-1:0] b);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    lanes <= b;
    req_rd <= !w;
    req_wr <= w;
    @(posedge clk);
    // only the watchdog ends a wait that never answers
    while (waitr !== 1'b0) begin
      @(posedge clk);
    end
    q = rdat;
    req_rd <= 1'b0;
    req_wr <= 1'b0;
  endtask
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    acc(1'b0, a, 32'h0, 4'hf);
    check(q, e);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    results();
  end

  // ------
  // scenarios
  // ------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({31'h0, waitr}, 32'h1);
    check(rdat, 32'h0);
    for (int i = 0; i < NUM_GPR; i++) begin
      rc(ad(RGN_FULL, i), GPR_RST);
      put(ad(RGN_FULL, i), pv(i));
      m[i] = pv(i);
    end
    for (int i = 0; i < NUM_GPR; i++) begin
      rc(ad(RGN_FULL, i), m[i]);
      put(ad(RGN_HALF, i), 32'hdead_5a00 | i);
      m[i][15:0] = 16'h5a00 | 16'(i);
      rc(ad(RGN_FULL, i), m[i]);
      rc(ad(RGN_HALF, i), {16'h0, m[i][15:0]});
    end
    for (int i = 0; i < NUM_BYTE_GPR; i++) begin
      put(ad(RGN_BYTE, i), 32'hffff_ff40 + i);
      m[i][7:0] = 8'h40 + 8'(i);
      rc(ad(RGN_FULL, i), m[i]);
      put(ad(RGN_BYTE, i + 4), 32'hffff_ff80 + i);
      m[i][15:8] = 8'h80 + 8'(i);
      rc(ad(RGN_FULL, i), m[i]);
      rc(ad(RGN_BYTE, i + 4), 32'h80 + i);
    end
    acc(1'b1, ad(RGN_FULL, 5), 32'haabb_ccdd, 4'b0100);
    m[5][23:16] = 8'hbb;
    rc(ad(RGN_FULL, 5), m[5]);
    for (int k = 0; k < 6; k++) begin
      put(ad_opsel, os(k, 1, 9, 1'b0));
      rc(ad_oper, (m[1] >> sh[k]) & mk[k]);
    end
    put(ad_opsel, os(MODE_WORD, 2, 0, 1'b0));
    rc(ad_addr, m[2]);
    put(ad_opsel, os(MODE_WORD, 2, 0, 1'b1));
    rc(ad_addr, {16'h0, m[2][15:0]});
    put(ad_opsel, os(MODE_BYTE1, 2, 0, 1'b0));
    rc(ad_addr, 32'h0);
    rc(ad_stat, 32'h1 << STAT_ADDR);
    put(ad_stat, 32'hf);
    put(ad_opsel, os(6, 0, 0, 1'b0));
    rc(ad_oper, 32'h0);
    rc(ad_stat, 32'h1 << STAT_MODE);
    put(ad_stat, 32'hf);
    put(ad_opsel, os(MODE_FIELD, 1, 9, 1'b0));
    put(ad_fwr, 32'hffff_ff55);
    m[1] = (m[1] & ~(32'h7f << 9)) | (32'h55 << 9);
    rc(ad(RGN_FULL, 1), m[1]);
    for (int k = 0; k < 3; k++) begin
      put(ad(RGN_SYS + 5'(k), k), pv(k + 8));
      rc(ad(RGN_SYS + 5'(k), k), pv(k + 8));
    end
    put(ad_cpl, 32'h3);
    rc(ad(RGN_SYS, 0), 32'h0);
    rc(ad(RGN_DBG, 1), 32'h0);
    put(ad(RGN_SYS, 0), 32'hffff_ffff);
    put(ad(RGN_DBG, 1), 32'hffff_ffff);
    rc(ad(RGN_FPU, 2), pv(10));
    rc(ad_stat, 32'h1 << STAT_PRIV);
    put(ad_stat, 32'hf);
    put(ad_cpl, 32'h0);
    rc(ad(RGN_SYS, 0), pv(8));
    rc(ad(RGN_DBG, 1), pv(9));
    for (int i = 0; i < NUM_GPR; i++) put(ad(RGN_STAGE, i), ~pv(i));
    for (int j = 0; j < NUM_SEG; j++) put(ad(RGN_STAGE_SEL, j), 32'h100 + j);
    put(ad_tsw, 32'h0);
    rc(ad_stat, 32'h1 << STAT_TSW);
    for (int i = 0; i < NUM_GPR; i++) begin
      rc(ad(RGN_FULL, i), ~pv(i));
      rc(ad(RGN_STAGE, i), m[i]);
      rc(ad(RGN_SEL, i), i < NUM_SEG ? 32'h100 + i : 32'h0);
      rc(ad(RGN_STAGE_SEL, i), 32'h0);
    end
    put(ad(5'h1f, 7), 32'hffff_ffff);
    rc(ad(5'h1f, 7), 32'h0);
    rc(ad_fwr, 32'h0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(ad(RGN_FULL, 3), GPR_RST);
    rc(ad_cpl, 32'h0);
    results();
  end
endmodule

/* rtl/gprf_operand_unit.sv */
// operand extract and insert for one register word
`timescale 1ns/1ps
module gprf_operand_unit
  import gprf_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  input wire logic [WIDTH-1:0] word_i, // register contents
  input wire gprf_mode_type mode_i, // operand size
  input wire logic [POS_W-1:0] pos_i, // bit or field start
  input wire logic [POS_W-1:0] len_m1_i, // field length less one
  input wire logic [WIDTH-1:0] ins_i, // value to insert
  output logic [WIDTH-1:0] ext_o, // extracted operand
  output logic [WIDTH-1:0] upd_o, // word after insert
  output logic legal_o // mode code legal
);

  if (WIDTH != DATA_W) begin : g_chk
    $error("operand unit width must be 32");
  end

  // ------------------------------------------------------------
  // mask and shift per operand size
  // ------------------------------------------------------------
  logic [WIDTH-1:0] mask;
  logic [POS_W-1:0] shift;
  logic [WIDTH-1:0] ones;
  logic [WIDTH-1:0] field_mask;

  assign ones = '1;
  assign field_mask = (ones >> (POS_W'(WIDTH - 1) - len_m1_i)) << pos_i;

  always_comb begin
    mask = '0;
    shift = '0;
    legal_o = 1'b1;
    unique case (mode_i)
      MODE_BIT: begin
        mask = WIDTH'(1) << pos_i;
        shift = pos_i;
      end
      MODE_BYTE0: begin
        mask = WIDTH'({BYTE_W{1'b1}});
      end
      MODE_BYTE1: begin
        mask = WIDTH'({BYTE_W{1'b1}}) << BYTE_W;
        shift = POS_W'(BYTE_W);
      end
      MODE_HALF: begin
        mask = WIDTH'({HALF_W{1'b1}});
      end
      MODE_WORD: begin
        mask = ones;
      end
      MODE_FIELD: begin
        mask = field_mask;
        shift = pos_i;
      end
      default: begin
        legal_o = 1'b0;
      end
    endcase
  end

  // other bits of the word pass untouched
  assign ext_o = (word_i & mask) >> shift;
  assign upd_o = (word_i & ~mask) | ((ins_i << shift) & mask);

endmodule

/* rtl/gprf_top.sv */
// general purpose register file behind an avalon-mm slave
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module gprf_top
  import gprf_pkg::*;
#(
  parameter int unsigned NUM_REGS = NUM_GPR
) (
  input wire logic CLK_I, // core clock
  input wire logic SYS_RST_I, // sync reset, active high
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I, // byte address
  input wire logic AVS_READ_I, // read request
  input wire logic AVS_WRITE_I, // write request
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I, // write data
  input wire logic [BE_W-1:0] AVS_BYTEENABLE_I, // byte lanes
  output logic [DATA_W-1:0] AVS_READDATA_O, // read data
  output logic AVS_WAITREQUEST_O // stall
);

  if (NUM_REGS != NUM_GPR) begin : g_chk
    $error("address map holds exactly eight registers");
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0] gpr_reg [NUM_REGS];
  logic [DATA_W-1:0] stage_reg [NUM_REGS];
  logic [HALF_W-1:0] sel_reg [NUM_SEG];
  logic [HALF_W-1:0] stage_sel_reg [NUM_SEG];
  logic [DATA_W-1:0] sys_reg [NUM_GPR];
  logic [DATA_W-1:0] dbg_reg [NUM_GPR];
  logic [DATA_W-1:0] fpu_reg [NUM_GPR];
  gprf_opsel_type opsel_reg;
  logic [CPL_W-1:0] cpl_reg;
  logic [STAT_W-1:0] stat_reg;
  logic [STAT_W-1:0] stat_next;
  logic wait_reg;
  logic [DATA_W-1:0] rdata_reg;

  // ------------------------------------------------------------
  // bus handshake: one wait cycle, then the access completes
  // ------------------------------------------------------------
  logic req;
  logic take;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] wd;

  assign req = AVS_READ_I | AVS_WRITE_I;
  assign take = req & ~wait_reg;
  assign wr = take & AVS_WRITE_I;
  assign rd = take & AVS_READ_I;
  assign wd = AVS_WRITEDATA_I;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [REGION_W-1:0] region;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] byte_src;
  logic byte_hi;
  logic priv_ok;
  logic priv_rgn;
  logic priv_bad;

  function automatic logic is_ctl(input logic [REGION_W-1:0] r,
                                  input logic [IDX_W-1:0] i,
                                  input logic [IDX_W-1:0] c);
    is_ctl = (r == RGN_CTRL) && (i == c);
  endfunction

  function automatic logic [DATA_W-1:0] be_merge(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [BE_W-1:0] be);
    be_merge = old_v;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        be_merge[b*BYTE_W +: BYTE_W] = new_v[b*BYTE_W +: BYTE_W];
      end
    end
  endfunction

  assign region = AVS_ADDRESS_I[ADDR_W-1:REGION_LSB];
  assign idx = AVS_ADDRESS_I[REGION_LSB-1:IDX_LSB];
  assign byte_hi = idx[IDX_W-1];
  assign byte_src = {1'b0, idx[IDX_W-2:0]};
  assign priv_ok = (cpl_reg == CPL_KERNEL);
  assign priv_rgn = (region == RGN_SYS) || (region == RGN_DBG);
  assign priv_bad = priv_rgn & ~priv_ok;

  // ------------------------------------------------------------
  // operand path
  // ------------------------------------------------------------
  logic [DATA_W-1:0] op_word;
  logic [DATA_W-1:0] op_ext;
  logic [DATA_W-1:0] op_upd;
  logic op_legal;
  logic op_byte;
  logic op_ok;
  logic [DATA_W-1:0] addr_val;
  logic addr_ok;

  assign op_word = gpr_reg[opsel_reg.src];

  gprf_operand_unit #(
    .WIDTH(DATA_W)
  ) u_operand (
    .word_i(op_word),
    .mode_i(opsel_reg.mode),
    .pos_i(opsel_reg.pos),
    .len_m1_i(opsel_reg.len_m1),
    .ins_i(wd),
    .ext_o(op_ext),
    .upd_o(op_upd),
    .legal_o(op_legal)
  );

  assign op_byte = (opsel_reg.mode == MODE_BYTE0) ||
                   (opsel_reg.mode == MODE_BYTE1);
  // byte operands exist only on the first four registers
  assign op_ok = op_legal &&
                 !(op_byte && (opsel_reg.src >= IDX_W'(NUM_BYTE_GPR)));
  // address operand is whole word or low half, never a byte
  assign addr_ok = op_legal && !op_byte;
  assign addr_val = opsel_reg.addr16 ?
                    DATA_W'(op_word[HALF_W-1:0]) : op_word;

  // ------------------------------------------------------------
  // write and read strobes
  // ------------------------------------------------------------
  logic wr_full;
  logic wr_half;
  logic wr_byte;
  logic wr_field;
  logic wr_tsw;
  logic rd_operand;
  logic rd_addrop;

  assign wr_full = wr && (region == RGN_FULL);
  assign wr_half = wr && (region == RGN_HALF);
  assign wr_byte = wr && (region == RGN_BYTE);
  assign wr_field = wr && is_ctl(region, idx, CTL_FIELD_WR) && op_ok;
  assign wr_tsw = wr && is_ctl(region, idx, CTL_TSW);
  assign rd_operand = rd && is_ctl(region, idx, CTL_OPERAND);
  assign rd_addrop = rd && is_ctl(region, idx, CTL_ADDROP);

  // ------------------------------------------------------------
  // general purpose registers
  // ------------------------------------------------------------
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_gpr
    logic [DATA_W-1:0] gpr_next;
    logic hit;
    logic bhit;

    assign hit = (idx == IDX_W'(g));
    assign bhit = wr_byte && (byte_src == IDX_W'(g));
    assign gpr_next =
      wr_tsw ? stage_reg[g] :
      (wr_full && hit) ? be_merge(gpr_reg[g], wd, AVS_BYTEENABLE_I) :
      (wr_half && hit) ?
        {gpr_reg[g][DATA_W-1:HALF_W], wd[HALF_W-1:0]} :
      (bhit && byte_hi) ? {gpr_reg[g][DATA_W-1:HALF_W],
        wd[BYTE_W-1:0], gpr_reg[g][BYTE_W-1:0]} :
      (bhit && !byte_hi) ?
        {gpr_reg[g][DATA_W-1:BYTE_W], wd[BYTE_W-1:0]} :
      (wr_field && (opsel_reg.src == IDX_W'(g))) ? op_upd :
      gpr_reg[g];

    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
        gpr_reg[g] <= GPR_RST;
        stage_reg[g] <= GPR_RST;
      end else begin
        gpr_reg[g] <= gpr_next;
        if (wr_tsw) begin
          stage_reg[g] <= gpr_reg[g]; // outgoing context saved
        end else if (wr && (region == RGN_STAGE) && hit) begin
          stage_reg[g] <= be_merge(stage_reg[g], wd, AVS_BYTEENABLE_I);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // segment selectors
  // ------------------------------------------------------------
  for (genvar s = 0; s < NUM_SEG; s++) begin : g_sel
    logic hit;

    assign hit = (idx == IDX_W'(s));

    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
        sel_reg[s] <= SEL_RST;
        stage_sel_reg[s] <= SEL_RST;
      end else if (wr_tsw) begin
        sel_reg[s] <= stage_sel_reg[s];
        stage_sel_reg[s] <= sel_reg[s];
      end else if (wr && hit && (region == RGN_SEL)) begin
        sel_reg[s] <= wd[HALF_W-1:0];
      end else if (wr && hit && (region == RGN_STAGE_SEL)) begin
        stage_sel_reg[s] <= wd[HALF_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // system, debug and floating point words
  // ------------------------------------------------------------
  for (genvar k = 0; k < NUM_GPR; k++) begin : g_aux
    logic hit;

    assign hit = wr && (idx == IDX_W'(k));

    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
        sys_reg[k] <= GPR_RST;
        dbg_reg[k] <= GPR_RST;
        fpu_reg[k] <= GPR_RST;
      end else begin
        if (hit && (region == RGN_SYS) && priv_ok) begin
          sys_reg[k] <= be_merge(sys_reg[k], wd, AVS_BYTEENABLE_I);
        end
        if (hit && (region == RGN_DBG) && priv_ok) begin
          dbg_reg[k] <= be_merge(dbg_reg[k], wd, AVS_BYTEENABLE_I);
        end
        if (hit && (region == RGN_FPU)) begin
          fpu_reg[k] <= be_merge(fpu_reg[k], wd, AVS_BYTEENABLE_I);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // control and status
  // ------------------------------------------------------------
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;

  assign stat_set[STAT_PRIV] = take && priv_bad;
  assign stat_set[STAT_ADDR] = rd_addrop && !addr_ok;
  assign stat_set[STAT_MODE] = (rd_operand ||
    (wr && is_ctl(region, idx, CTL_FIELD_WR))) && !op_ok;
  assign stat_set[STAT_TSW] = wr_tsw;
  assign stat_clr = (wr && is_ctl(region, idx, CTL_STATUS)) ?
                    wd[STAT_W-1:0] : '0;
  // a new event beats a clear in the same cycle
  assign stat_next = (stat_reg & ~stat_clr) | stat_set;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      opsel_reg <= OPSEL_RST;
      cpl_reg <= CPL_RST;
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
      if (wr && is_ctl(region, idx, CTL_OPSEL)) begin
        opsel_reg <= gprf_opsel_type'(wd);
      end
      if (wr && is_ctl(region, idx, CTL_CPL)) begin
        cpl_reg <= wd[CPL_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // read selection
  // ------------------------------------------------------------
  logic [DATA_W-1:0] rd_byte_val;
  logic [DATA_W-1:0] rd_ctl;
  logic [DATA_W-1:0] rd_sel;
  logic [DATA_W-1:0] rd_stage_sel;
  logic [DATA_W-1:0] rd_mux;

  assign rd_byte_val = byte_hi ?
    DATA_W'(gpr_reg[byte_src][HALF_W-1:BYTE_W]) :
    DATA_W'(gpr_reg[byte_src][BYTE_W-1:0]);
  assign rd_sel = (idx < IDX_W'(NUM_SEG)) ?
    DATA_W'(sel_reg[idx]) : '0;
  assign rd_stage_sel = (idx < IDX_W'(NUM_SEG)) ?
    DATA_W'(stage_sel_reg[idx]) : '0;
  assign rd_ctl =
    (idx == CTL_OPSEL) ? DATA_W'(opsel_reg) :
    (idx == CTL_OPERAND) ? (op_ok ? op_ext : '0) :
    (idx == CTL_ADDROP) ? (addr_ok ? addr_val : '0) :
    (idx == CTL_STATUS) ? DATA_W'(stat_reg) :
    (idx == CTL_CPL) ? DATA_W'(cpl_reg) : '0;
  assign rd_mux =
    (region == RGN_FULL) ? gpr_reg[idx] :
    (region == RGN_HALF) ? DATA_W'(gpr_reg[idx][HALF_W-1:0]) :
    (region == RGN_BYTE) ? rd_byte_val :
    (region == RGN_CTRL) ? rd_ctl :
    (region == RGN_SYS) ? (priv_ok ? sys_reg[idx] : '0) :
    (region == RGN_DBG) ? (priv_ok ? dbg_reg[idx] : '0) :
    (region == RGN_FPU) ? fpu_reg[idx] :
    (region == RGN_STAGE) ? stage_reg[idx] :
    (region == RGN_STAGE_SEL) ? rd_stage_sel :
    (region == RGN_SEL) ? rd_sel : '0;

  // ------------------------------------------------------------
  // bus outputs
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (req && wait_reg && AVS_READ_I) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign AVS_WAITREQUEST_O = wait_reg;
  assign AVS_READDATA_O = rdata_reg;

endmodule
